// ### verilog/tcg_pkg.sv
package tcg_pkg;
    // Register index 0x19 is not a multiple of four: byte address is four times the index
    localparam logic [7:0] REG_SETTINGS_IDX = 8'h19;
    localparam logic [9:0] REG_SETTINGS_ADDR = {REG_SETTINGS_IDX, 2'b00};
    localparam logic [9:0] REG_STATUS_ADDR = 10'h068;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_INVERT = 1;
    localparam int BIT_WIDTH5 = 2;
    localparam int SEL_LSB = 3;
    localparam int BIT_SKIP = 6;
    localparam int SEED_LSB = 16;
    localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
    localparam logic [31:0] SETTINGS_WMASK = 32'hFFFF_007F;
    localparam logic [2:0] SEL_CUSTOM = 3'h7;
    localparam logic [15:0] SEED_0 = 16'h0000;
    localparam logic [15:0] SEED_1 = 16'h6363;
    localparam logic [15:0] SEED_2 = 16'hA671;
    localparam logic [15:0] SEED_3 = 16'hFFFF;
    localparam logic [15:0] SEED_4 = 16'h0012;
    localparam logic [15:0] SEED_5 = 16'hE012;
    localparam logic [15:0] POLY16 = 16'h8408;
    localparam logic [4:0] POLY5 = 5'h14;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } tcg_byte_t;
endpackage : tcg_pkg

// ### verilog/tcg_crc_gen.sv
`timescale 1ns/1ps
// Overview of operation
// R01: Enable bit 0 appends checksum; else none
// R02: Bit 2 selects 16-bit or 5-bit checksum
// R03: Bit 1 complements checksum before sending
// R04: Bits 5:3 select fixed seed table
// R05: Code 111 uses programmable seed bits 31:16
// R06: 5-bit mode uses seed low byte only
// R07: Bit 6 skips first byte from checksum
// R08: Bits 15:7 read zero, ignore writes
// R09: Checksum after last byte, low first
module tcg_crc_gen import tcg_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic in_valid,
    output logic in_ready,
    input wire tcg_byte_t in_byte,
    output logic out_valid,
    input wire logic out_ready,
    output tcg_byte_t out_byte
);
    typedef enum {ST_DATA, ST_CRC_LO, ST_CRC_HI} tcg_state_t;

    logic [31:0] settings;
    logic [15:0] crc;
    logic first_pending;
    logic frames_done;
    tcg_state_t state;
    tcg_byte_t buf_q [2];
    logic [1:0] cnt;
    logic wr_ptr;
    logic rd_ptr;
    logic ap_write;
    logic ap_read;
    logic [9:0] ap_addr;

    function automatic logic [15:0] seed_of(input logic [2:0] sel, input logic [15:0] custom);
        case (sel)
            3'h1: seed_of = SEED_1;
            3'h2: seed_of = SEED_2;
            3'h3: seed_of = SEED_3;
            3'h4: seed_of = SEED_4;
            3'h5: seed_of = SEED_5;
            SEL_CUSTOM: seed_of = custom; // see R05
            default: seed_of = SEED_0; // see R04
        endcase
    endfunction : seed_of

    // Reflected update, bitwise LSB first like the air order
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d, input logic w5);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (w5) begin
                r[4:0] = (r[0] ^ d[i]) ? ((r[4:0] >> 1) ^ POLY5) : (r[4:0] >> 1);
                r[15:5] = 11'h000;
            end else begin
                r = (r[0] ^ d[i]) ? ((r >> 1) ^ POLY16) : (r >> 1);
            end
        end
        crc_step = r;
    endfunction : crc_step

    wire logic en = settings[BIT_ENABLE];
    wire logic inv = settings[BIT_INVERT];
    wire logic w5 = settings[BIT_WIDTH5];
    wire logic skip = settings[BIT_SKIP];
    wire logic [2:0] sel = settings[SEL_LSB +: 3];
    wire logic [15:0] seed_full = seed_of(sel, settings[SEED_LSB +: 16]);
    // Width mask applied at load so only low bits ever feed the 5-bit engine
    wire logic [15:0] seed = w5 ? {8'h00, seed_full[7:0]} : seed_full; // see R06
    wire logic [15:0] crc_out = inv ? ~crc : crc; // see R03

    // Bus slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ap_write <= 1'b0;
            ap_read <= 1'b0;
            ap_addr <= 10'h000;
        end else if (hready) begin
            ap_write <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            ap_read <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
            ap_addr <= haddr[9:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settings <= SETTINGS_RESET;
        end else if (ap_write && ap_addr == REG_SETTINGS_ADDR) begin
            settings <= hwdata & SETTINGS_WMASK; // see R08
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
            case (haddr[9:0])
                // Forward a write still in its data phase, so a read right behind it sees the new value
                REG_SETTINGS_ADDR: begin
                    if (ap_write && ap_addr == REG_SETTINGS_ADDR) begin
                        hrdata <= hwdata & SETTINGS_WMASK; // see R08
                    end else begin
                        hrdata <= settings;
                    end
                end
                REG_STATUS_ADDR: hrdata <= {8'h00, frames_done, 5'h00, state == ST_DATA ? 2'h0 : 2'h1, crc};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Two-entry output buffer
    wire logic buf_push;
    wire logic buf_pop = out_valid && out_ready;
    tcg_byte_t push_byte;
    assign out_valid = cnt != 2'h0;
    assign out_byte = buf_q[rd_ptr];
    wire logic room = cnt != 2'h2;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 2'h0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            cnt <= cnt + 2'(buf_push) - 2'(buf_pop);
            if (buf_push) wr_ptr <= ~wr_ptr;
            if (buf_pop) rd_ptr <= ~rd_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (buf_push) begin
            buf_q[wr_ptr] <= push_byte;
        end
    end

    // Stall input while checksum bytes are being appended
    assign in_ready = room && state == ST_DATA;
    wire logic take = in_valid && in_ready;
    assign buf_push = take || (room && state != ST_DATA);

    always_comb begin
        push_byte = in_byte;
        if (state == ST_CRC_LO) begin
            push_byte.data = w5 ? {3'h0, crc_out[4:0]} : crc_out[7:0]; // see R09
            push_byte.last = w5;
        end else if (state == ST_CRC_HI) begin
            push_byte.data = crc_out[15:8];
            push_byte.last = 1'b1;
        end else if (en) begin
            push_byte.last = 1'b0; // see R09
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_DATA;
        end else begin
            case (state)
                ST_DATA: if (take && in_byte.last && en) state <= ST_CRC_LO; // see R01
                ST_CRC_LO: if (room) state <= w5 ? ST_DATA : ST_CRC_HI; // see R02
                ST_CRC_HI: if (room) state <= ST_DATA;
                default: state <= ST_DATA;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc <= 16'h0000;
            first_pending <= 1'b1;
        end else if (state == ST_DATA && !take && first_pending) begin
            crc <= seed; // see R04
        end else if (take) begin
            first_pending <= in_byte.last;
            if (!(first_pending && skip)) begin
                crc <= crc_step(crc, in_byte.data, w5); // see R07
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frames_done <= 1'b0;
        end else if (state != ST_DATA && room && (w5 || state == ST_CRC_HI)) begin
            frames_done <= 1'b1;
        end
    end

    a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
        settings[15:7] == 9'h000) else $error("reserved bits not zero"); // see R08
    a_no_crc_disabled: assert property (@(posedge clk) disable iff (!arst_n)
        take && in_byte.last && !en |=> state == ST_DATA) else $error("checksum while disabled"); // see R01
    a_crc_after_last: assert property (@(posedge clk) disable iff (!arst_n)
        take && in_byte.last && en |=> state == ST_CRC_LO) else $error("no checksum after last"); // see R09
    sequence s_lo_sent;
        state == ST_CRC_LO && room && !w5;
    endsequence
    a_hi_follows_lo: assert property (@(posedge clk) disable iff (!arst_n)
        s_lo_sent |=> state == ST_CRC_HI) else $error("high byte missing"); // see R02
    a_five_bit_one: assert property (@(posedge clk) disable iff (!arst_n)
        state == ST_CRC_LO && room && w5 |=> state == ST_DATA) else $error("5-bit sends one byte"); // see R02
    a_invert_data: assert property (@(posedge clk) disable iff (!arst_n)
        state == ST_CRC_LO && !w5 |-> push_byte.data == (inv ? ~crc[7:0] : crc[7:0]))
        else $error("inversion wrong"); // see R03
    a_seed_load: assert property (@(posedge clk) disable iff (!arst_n)
        state == ST_DATA && !take && first_pending |=> crc == $past(seed))
        else $error("seed not loaded"); // see R04
    a_seed_custom: assert property (@(posedge clk) disable iff (!arst_n)
        sel == SEL_CUSTOM && !w5 |-> seed == settings[31:16]) else $error("custom seed wrong"); // see R05
    a_seed_low_byte: assert property (@(posedge clk) disable iff (!arst_n)
        w5 |-> seed[15:8] == 8'h00) else $error("5-bit seed upper byte used"); // see R06
    a_skip_first: assert property (@(posedge clk) disable iff (!arst_n)
        take && first_pending && skip |=> crc == $past(crc)) else $error("first byte not skipped"); // see R07
    a_buf_bound: assert property (@(posedge clk) disable iff (!arst_n)
        cnt <= 2'h2) else $error("buffer overflow");
endmodule : tcg_crc_gen

// ### tb/tcg_sink.sv
`timescale 1ns/1ps
module tcg_sink import tcg_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic out_valid,
    output logic out_ready,
    input wire tcg_byte_t out_byte
);
    logic [3:0] lfsr;
    tcg_byte_t got[$];
    // Stalls about a fifth of cycles, so the buffer fills
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lfsr <= 4'h9;
            out_ready <= 1'b0;
        end else begin
            lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
            out_ready <= lfsr[1:0] != 2'h0;
            if (out_valid && out_ready) begin
                got.push_back(out_byte);
            end
        end
    end
endmodule : tcg_sink

// ### tb/test_tx_frame_crc_generator.sv
`timescale 1ns/1ps
module test_tx_frame_crc_generator import tcg_pkg::*;;
    logic clk, arst_n, hsel, hwrite, hreadyout, hresp, in_valid, in_ready, out_valid, out_ready, w5, en;
    logic [31:0] haddr, hwdata, hrdata, r, cfg, rng;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] c, sd;
    logic [8:0] e[$];
    tcg_byte_t in_byte, out_byte;
    int fail_count, checked, n, k;
    tcg_crc_gen tcg_crc_gen_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_ready(in_ready), .in_byte(in_byte),
        .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte));
    tcg_sink tcg_sink_inst (.clk(clk), .arst_n(arst_n), .out_valid(out_valid), .out_ready(out_ready),
        .out_byte(out_byte));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    // Reflected, data LSB first; 5-bit register kept in bits 4:0
    function automatic logic [15:0] step(logic [15:0] v, logic [7:0] d, logic m5);
        logic fb;
        for (int i = 0; i < 8; i++) begin
            fb = v[0] ^ d[i];
            v = v >> 1;
            if (fb) v ^= m5 ? {11'h000, POLY5} : POLY16;
        end
        return v;
    endfunction : step
    task cmp(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask : cmp
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        cmp({31'h0, hresp}, 32'h0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task send(input logic [7:0] d, input logic l);
        in_valid <= 1'b1;
        in_byte <= '{data: d, last: l};
        do @(posedge clk); while (in_ready !== 1'b1);
    endtask : send
    task finish_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #500000;
        fail_count++;
        finish_test();
    end
    initial begin
        {arst_n, hsel, hwrite, in_valid, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        in_byte = '0;
        rng = 32'h7E77A726;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, {22'h0, REG_SETTINGS_ADDR}, 32'h0, r);
        cmp(r, SETTINGS_RESET);
        bus(1'b1, 32'h0000_0100, xs(), r);
        bus(1'b0, 32'h0000_0100, 32'h0, r);
        cmp(r, 32'h0);
        $display("test reset and unmapped done");
        for (int t = 0; t < 28; t++) begin
            cfg = xs();
            cfg[5:3] = (t % 7 == 6) ? SEL_CUSTOM : 3'(t % 7);
            cfg[0] = (t % 4 != 3);
            bus(1'b1, {22'h0, REG_SETTINGS_ADDR}, cfg, r);
            bus(1'b0, {22'h0, REG_SETTINGS_ADDR}, 32'h0, r);
            cmp(r, cfg & SETTINGS_WMASK);
            case (cfg[5:3])
                3'h0: sd = SEED_0;
                3'h1: sd = SEED_1;
                3'h2: sd = SEED_2;
                3'h3: sd = SEED_3;
                3'h4: sd = SEED_4;
                3'h5: sd = SEED_5;
                default: sd = cfg[31:16];
            endcase
            w5 = cfg[2];
            en = cfg[0];
            c = w5 ? {11'h000, sd[4:0]} : sd;
            n = 1 + int'(xs() % 4);
            e.delete();
            for (int i = 0; i < n; i++) begin
                r = xs();
                if (!(cfg[6] && i == 0)) c = step(c, r[7:0], w5);
                e.push_back({r[7:0], !en && i == n - 1});
                send(r[7:0], i == n - 1);
            end
            in_valid <= 1'b0;
            if (cfg[1]) c = ~c;
            if (en) e.push_back({c[7:0], w5});
            if (en && !w5) e.push_back({c[15:8], 1'b1});
            k = 0;
            while (tcg_sink_inst.got.size() < e.size() && k < 500) begin
                @(posedge clk);
                k++;
            end
            cmp(tcg_sink_inst.got.size(), e.size());
            if (tcg_sink_inst.got.size() == e.size()) begin
                foreach (e[i]) begin
                    // Upper bits of a 5-bit checksum byte are left open
                    k = (en && w5 && i == e.size() - 1) ? 32'h3F : 32'h1FF;
                    cmp(tcg_sink_inst.got[i] & k, e[i] & k);
                end
            end
            tcg_sink_inst.got.delete();
            $display("test frame %0d done", t);
        end
        finish_test();
    end
endmodule : test_tx_frame_crc_generator
